// ===== rtl/tsd_defines.svh
// Constants of the two-digit stopwatch display: timing, register map, fields and reset values.
`ifndef TSD_DEFINES_SVH
`define TSD_DEFINES_SVH

// ============================================================
// Timing
`define TSD_CLK_PERIOD_NS 50
`define TSD_TICK_NS 100000000
`define TSD_DEBOUNCE_NS 10000000

// ============================================================
// Register offsets
`define TSD_ADDR_CTRL 4'h0
`define TSD_ADDR_NUMBER 4'h1
`define TSD_ADDR_TOGGLE 4'h2
`define TSD_ADDR_STATUS 4'h3

// ============================================================
// Field positions
`define TSD_CTRL_MODE_MSB 1
`define TSD_CTRL_MODE_LSB 0
`define TSD_CTRL_RUN_BIT 2
`define TSD_CTRL_CLEAR_BIT 3
`define TSD_NUM_FIRST_MSB 3
`define TSD_NUM_FIRST_LSB 0
`define TSD_NUM_SECOND_MSB 7
`define TSD_NUM_SECOND_LSB 4
`define TSD_TOGGLE_MSB 13
`define TSD_STAT_STATE_LSB 0
`define TSD_STAT_TENTHS_LSB 4
`define TSD_STAT_SECS_LSB 8

// ============================================================
// Reset values and limits
`define TSD_RST_DIGIT 4'h0
`define TSD_RST_TOGGLE 14'h0000
`define TSD_MAX_DIGIT 4'h9

`endif

// ===== rtl/tsd_pkg.sv
// Types shared by the two-digit stopwatch display.
package tsd_pkg;

	typedef enum logic [1:0] {
		TSD_ST_CLEARED = 2'b00,
		TSD_ST_RUNNING = 2'b01,
		TSD_ST_STOPPED = 2'b10
	} tsd_state_t;

	typedef enum logic [1:0] {
		TSD_MODE_STOPWATCH = 2'b00,
		TSD_MODE_NUMBER = 2'b01,
		TSD_MODE_TOGGLE = 2'b10
	} tsd_mode_t;

	typedef logic [3:0] tsd_bcd_t;
	typedef logic [6:0] tsd_seg_t;
	typedef logic [15:0] tsd_word_t;
	typedef logic [3:0] tsd_addr_t;

endpackage

// ===== rtl/tsd_debounce.sv
// Button synchroniser and debouncer giving one pulse per press edge.
`timescale 1ns/100ps
module tsd_debounce #(
	parameter int unsigned STABLE_CYCLES = 200000
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic srst_in,
	// Raw button, high while pressed
	input wire logic button_in,
	// One-cycle pulse per accepted press
	output logic press_out
);

	logic sync1_reg, sync2_reg, stable_reg, press_reg;
	logic stable_next, press_next;
	logic [19:0] cnt_reg, cnt_next;

	// ============================================================
	// Debounce
	// A change must hold for the whole window; any bounce restarts it.
	always_comb begin
		stable_next = stable_reg;
		press_next = 1'b0;
		cnt_next = 20'h00000;
		if (sync2_reg != stable_reg) begin
			if (cnt_reg == 20'(STABLE_CYCLES - 1)) begin
				stable_next = sync2_reg;
				press_next = sync2_reg;
			end else begin
				cnt_next = cnt_reg + 20'h00001;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			stable_reg <= 1'b0;
			press_reg <= 1'b0;
			cnt_reg <= 20'h00000;
		end else begin
			sync1_reg <= button_in;
			sync2_reg <= sync1_reg;
			stable_reg <= stable_next;
			press_reg <= press_next;
			cnt_reg <= cnt_next;
		end
	end

	assign press_out = press_reg;

	a_press_one_cycle: assert property (
		@(posedge sys_clk_in) disable iff (srst_in)
		press_reg |=> !press_reg
	) else $error("Press pulse lasted more than one cycle.");

	a_press_after_hold: assert property (
		@(posedge sys_clk_in) disable iff (srst_in)
		$rose(press_reg) |-> stable_reg && $past(sync2_reg) && !$past(stable_reg)
	) else $error("Press pulse without a debounced rising edge.");

endmodule // tsd_debounce

// ===== rtl/tsd_top.sv
// Two-digit stopwatch display: buttons, tenth-second timer, controller and segment drive.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`include "tsd_defines.svh"
module tsd_top #(
	parameter int unsigned TICK_CYCLES = `TSD_TICK_NS / `TSD_CLK_PERIOD_NS,
	parameter int unsigned DEBOUNCE_CYCLES = `TSD_DEBOUNCE_NS / `TSD_CLK_PERIOD_NS
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic srst_in,
	// Push-buttons, high while pressed
	input wire logic run_toggle_button_in,
	input wire logic clear_button_in,
	// Register port
	input wire tsd_pkg::tsd_addr_t reg_addr_in,
	input wire tsd_pkg::tsd_word_t reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output tsd_pkg::tsd_word_t reg_rdata_out,
	// Segment drive, active low, bit 0 is segment a
	output tsd_pkg::tsd_seg_t seg_first_n_out,
	output tsd_pkg::tsd_seg_t seg_second_n_out,
	output logic fixed_point_segment_n_out,
	output logic spare_point_segment_n_out
);
	import tsd_pkg::*;

	// ============================================================
	// Helpers
	// Pattern bits are gfedcba with 1 meaning lit; codes above nine show blank.
	function automatic tsd_seg_t seg_encode(input tsd_bcd_t d);
		case (d)
			4'h0: return 7'h3f;
			4'h1: return 7'h06;
			4'h2: return 7'h5b;
			4'h3: return 7'h4f;
			4'h4: return 7'h66;
			4'h5: return 7'h6d;
			4'h6: return 7'h7d;
			4'h7: return 7'h07;
			4'h8: return 7'h7f;
			4'h9: return 7'h6f;
			default: return 7'h00;
		endcase
	endfunction

	function automatic logic addr_hit(input tsd_addr_t a, input tsd_addr_t target);
		return a == target;
	endfunction

	// ============================================================
	// Button events
	logic run_press, clear_press;

	tsd_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_run_debounce (
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.button_in(run_toggle_button_in),
		.press_out(run_press)
	);

	tsd_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_clear_debounce (
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.button_in(clear_button_in),
		.press_out(clear_press)
	);

	// Software commands act exactly like the buttons.
	logic ctrl_wr, run_evt, clear_evt;
	assign ctrl_wr = reg_wr_in && addr_hit(reg_addr_in, `TSD_ADDR_CTRL);
	assign run_evt = run_press || (ctrl_wr && reg_wdata_in[`TSD_CTRL_RUN_BIT]);
	assign clear_evt = clear_press || (ctrl_wr && reg_wdata_in[`TSD_CTRL_CLEAR_BIT]);

	// ============================================================
	// Controller and elapsed time
	tsd_state_t state_reg, state_next;
	tsd_bcd_t tenths_reg, tenths_next, secs_reg, secs_next;
	logic tick, at_max, start_evt;

	assign at_max = (secs_reg == `TSD_MAX_DIGIT) && (tenths_reg == `TSD_MAX_DIGIT);
	assign start_evt = run_evt && !clear_evt && (state_reg != TSD_ST_RUNNING);

	always_comb begin
		state_next = state_reg;
		tenths_next = tenths_reg;
		secs_next = secs_reg;
		unique case (state_reg)
			TSD_ST_CLEARED: begin
				if (run_evt && !clear_evt) begin
					state_next = TSD_ST_RUNNING;
				end
			end
			TSD_ST_RUNNING: begin
				if (clear_evt) begin
					state_next = TSD_ST_CLEARED;
					tenths_next = `TSD_RST_DIGIT;
					secs_next = `TSD_RST_DIGIT;
				end else if (run_evt) begin
					state_next = TSD_ST_STOPPED;
				end else if (tick && !at_max) begin
					if (tenths_reg == `TSD_MAX_DIGIT) begin
						tenths_next = `TSD_RST_DIGIT;
						secs_next = secs_reg + 4'h1;
					end else begin
						tenths_next = tenths_reg + 4'h1;
					end
				end
			end
			TSD_ST_STOPPED: begin
				if (clear_evt) begin
					state_next = TSD_ST_CLEARED;
					tenths_next = `TSD_RST_DIGIT;
					secs_next = `TSD_RST_DIGIT;
				end else if (run_evt) begin
					state_next = TSD_ST_RUNNING;
				end
			end
			default: begin
				state_next = TSD_ST_CLEARED;
				tenths_next = `TSD_RST_DIGIT;
				secs_next = `TSD_RST_DIGIT;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			state_reg <= TSD_ST_CLEARED;
			tenths_reg <= `TSD_RST_DIGIT;
			secs_reg <= `TSD_RST_DIGIT;
		end else begin
			state_reg <= state_next;
			tenths_reg <= tenths_next;
			secs_reg <= secs_next;
		end
	end

	// ============================================================
	// Tenth-second timer
	// Restarted on every start so the first tenth after a start is a full one.
	logic [20:0] tick_cnt_reg, tick_cnt_next;

	always_comb begin
		tick = (tick_cnt_reg == 21'(TICK_CYCLES - 1));
		if (tick || start_evt) begin
			tick_cnt_next = 21'h000000;
		end else begin
			tick_cnt_next = tick_cnt_reg + 21'h000001;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			tick_cnt_reg <= 21'h000000;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
		end
	end

	// ============================================================
	// Configuration registers
	tsd_mode_t mode_reg, mode_next;
	tsd_bcd_t first_num_reg, first_num_next, second_num_reg, second_num_next;
	logic [13:0] toggle_reg, toggle_next;

	always_comb begin
		mode_next = mode_reg;
		first_num_next = first_num_reg;
		second_num_next = second_num_reg;
		toggle_next = toggle_reg;
		if (ctrl_wr) begin
			mode_next = tsd_mode_t'(reg_wdata_in[`TSD_CTRL_MODE_MSB:`TSD_CTRL_MODE_LSB]);
		end
		if (reg_wr_in && addr_hit(reg_addr_in, `TSD_ADDR_NUMBER)) begin
			first_num_next = reg_wdata_in[`TSD_NUM_FIRST_MSB:`TSD_NUM_FIRST_LSB];
			second_num_next = reg_wdata_in[`TSD_NUM_SECOND_MSB:`TSD_NUM_SECOND_LSB];
		end
		if (reg_wr_in && addr_hit(reg_addr_in, `TSD_ADDR_TOGGLE)) begin
			toggle_next = toggle_reg ^ reg_wdata_in[`TSD_TOGGLE_MSB:0];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			mode_reg <= TSD_MODE_STOPWATCH;
			first_num_reg <= `TSD_RST_DIGIT;
			second_num_reg <= `TSD_RST_DIGIT;
			toggle_reg <= `TSD_RST_TOGGLE;
		end else begin
			mode_reg <= mode_next;
			first_num_reg <= first_num_next;
			second_num_reg <= second_num_next;
			toggle_reg <= toggle_next;
		end
	end

	// ============================================================
	// Register read port
	tsd_word_t rdata_reg, rdata_next;

	always_comb begin
		rdata_next = 16'h0000;
		if (reg_rd_in) begin
			case (reg_addr_in)
				`TSD_ADDR_CTRL: rdata_next = {14'h0000, mode_reg};
				`TSD_ADDR_NUMBER: rdata_next = {8'h00, second_num_reg, first_num_reg};
				`TSD_ADDR_TOGGLE: rdata_next = {2'h0, toggle_reg};
				`TSD_ADDR_STATUS: rdata_next = {4'h0, secs_reg, tenths_reg, 2'h0, state_reg};
				default: rdata_next = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			rdata_reg <= 16'h0000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end
	assign reg_rdata_out = rdata_reg;

	// ============================================================
	// Segment drive
	// In stopwatch and spare modes the display follows the time one cycle after it changes.
	tsd_seg_t seg_first_reg, seg_first_next, seg_second_reg, seg_second_next;

	always_comb begin
		unique case (mode_reg)
			TSD_MODE_NUMBER: begin
				seg_first_next = ~seg_encode(first_num_reg);
				seg_second_next = ~seg_encode(second_num_reg);
			end
			TSD_MODE_TOGGLE: begin
				seg_first_next = ~toggle_reg[6:0];
				seg_second_next = ~toggle_reg[13:7];
			end
			// Stopwatch mode and the spare mode code both show the time.
			default: begin
				seg_first_next = ~seg_encode(secs_reg);
				seg_second_next = ~seg_encode(tenths_reg);
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			seg_first_reg <= ~seg_encode(`TSD_RST_DIGIT);
			seg_second_reg <= ~seg_encode(`TSD_RST_DIGIT);
		end else begin
			seg_first_reg <= seg_first_next;
			seg_second_reg <= seg_second_next;
		end
	end
	assign seg_first_n_out = seg_first_reg;
	assign seg_second_n_out = seg_second_reg;
	assign fixed_point_segment_n_out = 1'b0;
	assign spare_point_segment_n_out = 1'b1;

	// ============================================================
	// Checks
	a_points_fixed: assert property (
		@(posedge sys_clk_in) disable iff (srst_in)
		!fixed_point_segment_n_out && spare_point_segment_n_out
	) else $error("Decimal points not in their fixed state.");
	a_start_runs: assert property (
		@(posedge sys_clk_in) disable iff (srst_in)
		(state_reg == TSD_ST_CLEARED) && run_evt && !clear_evt |=> state_reg == TSD_ST_RUNNING
	) else $error("Start press did not enter running state.");
	a_run_toggles: assert property (
		@(posedge sys_clk_in) disable iff (srst_in)
		(state_reg == TSD_ST_RUNNING) && run_evt && !clear_evt |=> state_reg == TSD_ST_STOPPED
	) else $error("Run press while running did not stop.");
	a_stop_freezes: assert property (
		@(posedge sys_clk_in) disable iff (srst_in)
		(state_reg == TSD_ST_STOPPED) && !run_evt && !clear_evt
		|=> $stable(tenths_reg) && $stable(secs_reg)
	) else $error("Time changed while stopped.");
	a_clear_zero: assert property (
		@(posedge sys_clk_in) disable iff (srst_in)
		clear_evt |=> (tenths_reg == 4'h0) && (secs_reg == 4'h0) && (state_reg == TSD_ST_CLEARED)
	) else $error("Clear did not return the time to zero.");
	a_tenth_step: assert property (
		@(posedge sys_clk_in) disable iff (srst_in)
		(state_reg == TSD_ST_RUNNING) && tick && !run_evt && !clear_evt && (tenths_reg < 4'h9)
		|=> (tenths_reg == $past(tenths_reg) + 4'h1) && $stable(secs_reg)
	) else $error("Running tick did not add one tenth.");
	a_tenth_carry: assert property (
		@(posedge sys_clk_in) disable iff (srst_in)
		(state_reg == TSD_ST_RUNNING) && tick && !run_evt && !clear_evt
		&& (tenths_reg == 4'h9) && (secs_reg < 4'h9)
		|=> (tenths_reg == 4'h0) && (secs_reg == $past(secs_reg) + 4'h1)
	) else $error("Tenths did not wrap with carry.");
	a_hold_at_max: assert property (
		@(posedge sys_clk_in) disable iff (srst_in)
		at_max && !clear_evt |=> at_max
	) else $error("Time left 9.9 without a clear.");
	a_no_count_idle: assert property (
		@(posedge sys_clk_in) disable iff (srst_in)
		(state_reg != TSD_ST_RUNNING) && !clear_evt |=> $stable(tenths_reg)
	) else $error("Time advanced outside running state.");
	a_tick_restart: assert property (
		@(posedge sys_clk_in) disable iff (srst_in)
		tick |=> (tick_cnt_reg == 21'h000000) ##1 !tick
	) else $error("Tick timer did not restart after a tick.");
	a_stopwatch_shown: assert property (
		@(posedge sys_clk_in) disable iff (srst_in)
		(mode_reg == TSD_MODE_STOPWATCH) ##1 (mode_reg == TSD_MODE_STOPWATCH)
		|-> (seg_first_n_out == ~seg_encode($past(secs_reg)))
		&& (seg_second_n_out == ~seg_encode($past(tenths_reg)))
	) else $error("Stopwatch digits do not match the time.");
	a_toggle_shown: assert property (
		@(posedge sys_clk_in) disable iff (srst_in)
		(mode_reg == TSD_MODE_TOGGLE) |=> {seg_second_n_out, seg_first_n_out} == ~$past(toggle_reg)
	) else $error("Toggle mode segments do not follow toggle state.");

endmodule // tsd_top

// ===== verification/tsd_panel_model.sv
// Panel model: common-anode two-digit display and its two push-buttons.
`timescale 1ns/100ps
module tsd_panel_model (
	// Clock
	input wire logic sys_clk_in,
	// Segment lines, low sinks the cathode
	input wire logic [6:0] seg_first_n_in,
	input wire logic [6:0] seg_second_n_in,
	// Buttons, high while pressed
	output logic run_toggle_button_out,
	output logic clear_button_out,
	// Digit seen on each position, 4'hf when the shape is no digit
	output logic [3:0] first_digit_out,
	output logic [3:0] second_digit_out
);
	// ============================================================
	// Display
	localparam logic [6:0] SHAPES [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
		7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};

	function automatic logic [3:0] tsd_decode(input logic [6:0] seg_n);
		logic [3:0] d;
		d = 4'hf;
		for (int i = 0; i < 10; i++) begin
			if (~seg_n === SHAPES[i]) begin
				d = i[3:0];
			end
		end
		return d;
	endfunction

	assign first_digit_out = tsd_decode(seg_first_n_in);
	assign second_digit_out = tsd_decode(seg_second_n_in);

	// ============================================================
	// Buttons
	initial begin
		run_toggle_button_out = 1'b0;
		clear_button_out = 1'b0;
	end

	// A real contact chatters, so each press opens with a one-cycle bounce.
	task automatic press(input bit clear);
		for (int i = 0; i < 30; i++) begin
			@(posedge sys_clk_in);
			if (clear) begin
				clear_button_out <= (i != 1) && (i < 16);
			end else begin
				run_toggle_button_out <= (i != 1) && (i < 16);
			end
		end
	endtask
endmodule // tsd_panel_model

// ===== verification/tsd_top_bench.sv
// Self-checking bench of the two-digit stopwatch display.
`timescale 1ns/100ps
module tsd_top_bench;
	import tsd_pkg::*;
	localparam int TICK = 20;
	logic sys_clk_in = 1'b0;
	logic srst_in = 1'b1;
	tsd_addr_t reg_addr = 4'h0;
	tsd_word_t reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	tsd_word_t rdata;
	tsd_seg_t seg1_n;
	tsd_seg_t seg2_n;
	logic fp_n;
	logic sp_n;
	logic run_btn;
	logic clr_btn;
	logic [3:0] d1;
	logic [3:0] d2;
	tsd_word_t a;
	tsd_word_t b;
	int failures = 0;
	int cmp_count = 0;

	always #25 sys_clk_in = ~sys_clk_in;

	tsd_top #(.TICK_CYCLES(TICK), .DEBOUNCE_CYCLES(4)) tsd_top_i (
		.sys_clk_in(sys_clk_in), .srst_in(srst_in),
		.run_toggle_button_in(run_btn), .clear_button_in(clr_btn),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .reg_rdata_out(rdata), .seg_first_n_out(seg1_n),
		.seg_second_n_out(seg2_n), .fixed_point_segment_n_out(fp_n),
		.spare_point_segment_n_out(sp_n)
	);

	tsd_panel_model tsd_panel_model_i (
		.sys_clk_in(sys_clk_in), .seg_first_n_in(seg1_n), .seg_second_n_in(seg2_n),
		.run_toggle_button_out(run_btn), .clear_button_out(clr_btn),
		.first_digit_out(d1), .second_digit_out(d2)
	);

	// ============================================================
	// Shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input tsd_addr_t ad, input tsd_word_t d);
		@(posedge sys_clk_in);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic rd(input tsd_addr_t ad, output tsd_word_t d);
		@(posedge sys_clk_in);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic test_done;
		$display("Comparisons %0d, failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ============================================================
	// Scenarios
	task automatic t_reset;
		@(negedge sys_clk_in);
		chk({seg1_n, seg2_n, fp_n, sp_n}, {7'h40, 7'h40, 1'b0, 1'b1});
		rd(4'h3, a);
		chk(a, 16'h0000);
		rd(4'h0, a);
		chk(a, 16'h0000);
		rd(4'h7, a);
		chk(a, 16'h0000);
	endtask

	task automatic t_start_tick;
		int n;
		logic [3:0] v;
		tsd_panel_model_i.press(1'b0);
		rd(4'h3, a);
		chk(a & 16'h0003, 16'h0001);
		for (int k = 0; k < 2; k++) begin
			v = d2;
			n = 0;
			while (d2 === v && n < 200) begin
				@(negedge sys_clk_in);
				n++;
			end
		end
		chk(n[15:0], TICK[15:0]);
	endtask

	task automatic t_stop_resume;
		tsd_panel_model_i.press(1'b0);
		rd(4'h3, a);
		chk(a & 16'h0003, 16'h0002);
		repeat (60) @(posedge sys_clk_in);
		rd(4'h3, b);
		chk(b, a);
		chk({d1, d2}, a[11:4]);
		wr(4'h0, 16'h0004);
		rd(4'h3, a);
		chk(a & 16'h0003, 16'h0001);
		repeat (2200) @(posedge sys_clk_in);
		rd(4'h3, a);
		chk(a, 16'h0991);
		chk({d1, d2}, 8'h99);
	endtask

	task automatic t_clear;
		tsd_panel_model_i.press(1'b0);
		rd(4'h3, a);
		chk(a, 16'h0992);
		tsd_panel_model_i.press(1'b1);
		rd(4'h3, a);
		chk(a, 16'h0000);
		chk({d1, d2}, 8'h00);
		wr(4'h3, 16'hffff);
		rd(4'h3, a);
		chk(a, 16'h0000);
		wr(4'h0, 16'h0004);
		repeat (25) @(posedge sys_clk_in);
		rd(4'h3, a);
		chk(a, 16'h0011);
		wr(4'h0, 16'h0008);
		rd(4'h3, a);
		chk(a, 16'h0000);
	endtask

	task automatic t_number;
		wr(4'h0, 16'h0001);
		for (int i = 0; i < 10; i++) begin
			wr(4'h1, {8'h00, 4'(9 - i), 4'(i)});
			repeat (3) @(posedge sys_clk_in);
			chk({d1, d2}, {4'(i), 4'(9 - i)});
		end
		rd(4'h1, a);
		chk(a, 16'h0009);
		repeat (2) @(negedge sys_clk_in);
		chk(rdata, 16'h0000);
		rd(4'h0, a);
		chk(a, 16'h0001);
		wr(4'h0, 16'h0003);
		repeat (3) @(posedge sys_clk_in);
		chk({d1, d2}, 8'h00);
	endtask

	task automatic t_toggle;
		wr(4'h0, 16'h0002);
		wr(4'h2, 16'h0001);
		wr(4'h2, 16'h2000);
		repeat (3) @(posedge sys_clk_in);
		chk({seg1_n, seg2_n}, {7'h7e, 7'h3f});
		wr(4'h2, 16'h0001);
		rd(4'h2, a);
		chk(a, 16'h2000);
		chk({fp_n, sp_n}, 2'b01);
	endtask

	// ============================================================
	// Main sequence and watchdog
	initial begin
		repeat (4) @(posedge sys_clk_in);
		srst_in <= 1'b0;
		@(posedge sys_clk_in);
		t_reset();
		t_start_tick();
		t_stop_resume();
		t_clear();
		t_number();
		t_toggle();
		test_done();
	end

	initial begin
		repeat (20000) @(posedge sys_clk_in);
		failures++;
		test_done();
	end
endmodule // tsd_top_bench
